//--- hw/tuner_control_registers.sv
`timescale 1ns/1ps
module tuner_control_registers (
  input  wire logic       clk_i,
  input  wire logic       nrst_i,
  input  wire logic       wr_en_i,
  input  wire logic       rd_en_i,
  input  wire logic [3:0] addr_i,
  input  wire logic [7:0] wdata_i,
  output logic      [7:0] rdata_o,
  output logic            rvalid_o,
  output logic      [6:0] ref_divide_o,
  output logic      [2:0] core_enable_o,
  output logic      [7:0] sub_band_sel_o,
  output logic            lock_detect_enable_o,
  output logic      [3:0] oscillator_output_divider_o,
  output logic      [2:0] overload_threshold_o,
  output logic      [3:0] pump_current_select_o,
  output logic            filter_band_select_o,
  output logic            front_end_power_down_o,
  output logic            gain_amp_power_down_o,
  output logic      [1:0] rf_source_select_o,
  output logic            low_band_lpf_o,
  output logic            low_band_input_o,
  output logic            high_band_input_o,
  output logic            mixer_power_down_o,
  output logic            intermediate_stage_power_down_o,
  output logic            detector_power_down_o,
  output logic            synthesizer_power_down_o,
  output logic      [7:0] series_cap_code_o
);
  //==============================================================
  // register storage
  logic [7:0] ref_div_q, osc_q, ovld_q, ctrl_q, pwr_q, cap_q;
  logic [7:0] nxt_rdata;
  logic [3:0] core_sel;
  logic [7:0] subb_sel;
  logic [3:0] odiv_sel;
  logic [3:0] pump_sel;

  reg_byte #(.MASK(tuner_regs_pkg::MASK_REF_DIV), .RST_V(tuner_regs_pkg::RST_REF_DIV)) u_ref (
    .clk_i(clk_i), .nrst_i(nrst_i), .we_i(wr_en_i && addr_i == tuner_regs_pkg::ADDR_REF_DIV),
    .wdata_i(wdata_i), .q_o(ref_div_q));
  reg_byte #(.MASK(tuner_regs_pkg::MASK_OSC), .RST_V(tuner_regs_pkg::RST_OSC)) u_osc (
    .clk_i(clk_i), .nrst_i(nrst_i), .we_i(wr_en_i && addr_i == tuner_regs_pkg::ADDR_OSC),
    .wdata_i(wdata_i), .q_o(osc_q));
  reg_byte #(.MASK(tuner_regs_pkg::MASK_OVLD_PUMP), .RST_V(tuner_regs_pkg::RST_OVLD_PUMP)) u_ovl (
    .clk_i(clk_i), .nrst_i(nrst_i), .we_i(wr_en_i && addr_i == tuner_regs_pkg::ADDR_OVLD_PUMP),
    .wdata_i(wdata_i), .q_o(ovld_q));
  reg_byte #(.MASK(tuner_regs_pkg::MASK_CTRL), .RST_V(tuner_regs_pkg::RST_CTRL)) u_ctl (
    .clk_i(clk_i), .nrst_i(nrst_i), .we_i(wr_en_i && addr_i == tuner_regs_pkg::ADDR_CTRL),
    .wdata_i(wdata_i), .q_o(ctrl_q));
  reg_byte #(.MASK(tuner_regs_pkg::MASK_PWR_DOWN), .RST_V(tuner_regs_pkg::RST_PWR_DOWN)) u_pwr (
    .clk_i(clk_i), .nrst_i(nrst_i), .we_i(wr_en_i && addr_i == tuner_regs_pkg::ADDR_PWR_DOWN),
    .wdata_i(wdata_i), .q_o(pwr_q));
  reg_byte #(.MASK(tuner_regs_pkg::MASK_SER_CAP), .RST_V(tuner_regs_pkg::RST_SER_CAP)) u_cap (
    .clk_i(clk_i), .nrst_i(nrst_i), .we_i(wr_en_i && addr_i == tuner_regs_pkg::ADDR_SER_CAP),
    .wdata_i(wdata_i), .q_o(cap_q));

  //==============================================================
  // field decode
  one_hot_dec #(.W(2)) u_core (
    .code_i(osc_q[tuner_regs_pkg::CORE_LSB +: 2]), .sel_o(core_sel));
  one_hot_dec #(.W(3)) u_subb (
    .code_i(osc_q[tuner_regs_pkg::SUBB_LSB +: 3]), .sel_o(subb_sel));
  one_hot_dec #(.W(2)) u_odiv (
    .code_i(osc_q[tuner_regs_pkg::ODIV_LSB +: 2]), .sel_o(odiv_sel));
  one_hot_dec #(.W(2)) u_pump (
    .code_i(ovld_q[tuner_regs_pkg::PUMP_LSB +: 2]), .sel_o(pump_sel));

  //==============================================================
  // analogue controls, registered so each output is a flip-flop
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ref_divide_o                    <= 7'h00;
      core_enable_o                   <= 3'h0;
      sub_band_sel_o                  <= 8'h00;
      lock_detect_enable_o            <= 1'b0;
      oscillator_output_divider_o     <= 4'h0;
      overload_threshold_o            <= 3'h0;
      pump_current_select_o           <= 4'h0;
      filter_band_select_o            <= 1'b0;
      front_end_power_down_o          <= 1'b1;
      gain_amp_power_down_o           <= 1'b1;
      rf_source_select_o              <= 2'h0;
      low_band_lpf_o                  <= 1'b0;
      low_band_input_o                <= 1'b0;
      high_band_input_o               <= 1'b0;
      mixer_power_down_o              <= 1'b1;
      intermediate_stage_power_down_o <= 1'b1;
      detector_power_down_o           <= 1'b1;
      synthesizer_power_down_o        <= 1'b1;
      series_cap_code_o               <= 8'h00;
    end else begin
      ref_divide_o                    <= ref_div_q[6:0];
      core_enable_o                   <= core_sel[3:1];
      sub_band_sel_o                  <= subb_sel;
      lock_detect_enable_o            <= osc_q[tuner_regs_pkg::LOCK_BIT];
      oscillator_output_divider_o     <= odiv_sel;
      overload_threshold_o            <= ovld_q[tuner_regs_pkg::OVLD_LSB +: 3];
      pump_current_select_o           <= pump_sel;
      filter_band_select_o            <= ovld_q[tuner_regs_pkg::BAND_BIT];
      front_end_power_down_o          <= ctrl_q[tuner_regs_pkg::FEPD_BIT];
      gain_amp_power_down_o           <= ctrl_q[tuner_regs_pkg::VGAPD_BIT];
      rf_source_select_o              <= ctrl_q[tuner_regs_pkg::SRC_LSB +: 2];
      low_band_lpf_o                  <= ctrl_q[1:0] == 2'h0;
      low_band_input_o                <= ctrl_q[1] == 1'b0;
      high_band_input_o               <= ctrl_q[1:0] == 2'h2;
      // factory codes leave the mixer running; only 11 turns it off
      mixer_power_down_o              <= pwr_q[tuner_regs_pkg::MIX_LSB +: 2]
                                         == tuner_regs_pkg::MIX_OFF;
      intermediate_stage_power_down_o <= pwr_q[tuner_regs_pkg::IFPD_BIT];
      detector_power_down_o           <= pwr_q[tuner_regs_pkg::DETPD_BIT];
      synthesizer_power_down_o        <= pwr_q[tuner_regs_pkg::SYNPD_BIT];
      series_cap_code_o               <= cap_q;
    end
  end

  //==============================================================
  // read back
  always_comb begin
    case (addr_i)
      tuner_regs_pkg::ADDR_REF_DIV:   nxt_rdata = ref_div_q;
      tuner_regs_pkg::ADDR_OSC:       nxt_rdata = osc_q;
      tuner_regs_pkg::ADDR_OVLD_PUMP: nxt_rdata = ovld_q;
      tuner_regs_pkg::ADDR_CTRL:      nxt_rdata = ctrl_q;
      tuner_regs_pkg::ADDR_PWR_DOWN:  nxt_rdata = pwr_q;
      tuner_regs_pkg::ADDR_SER_CAP:   nxt_rdata = cap_q;
      default:                        nxt_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_o  <= 8'h00;
      rvalid_o <= 1'b0;
    end else begin
      rvalid_o <= rd_en_i;
      if (rd_en_i) begin
        rdata_o <= nxt_rdata;
      end
    end
  end

  //==============================================================
  // checks
  AST_READBACK: assert property (@(posedge clk_i) disable iff (!nrst_i)
    wr_en_i && !rd_en_i && addr_i == tuner_regs_pkg::ADDR_SER_CAP ##1
    rd_en_i && !wr_en_i && addr_i == tuner_regs_pkg::ADDR_SER_CAP
    |=> rvalid_o && rdata_o == $past(wdata_i, 2))
    else $error("read back differs from last write");
  AST_REF_RSVD: assert property (@(posedge clk_i) disable iff (!nrst_i)
    ref_div_q[7] == 1'b0)
    else $error("reference divider reserved bit set");
  AST_CORE_OFF: assert property (@(posedge clk_i) disable iff (!nrst_i)
    osc_q[7:6] == 2'h0 |=> core_enable_o == 3'h0)
    else $error("core enabled with select 00");
  AST_SUBBAND: assert property (@(posedge clk_i) disable iff (!nrst_i)
    1'b1 |=> sub_band_sel_o == 8'(1 << $past(osc_q[5:3])))
    else $error("sub-band decode wrong");
  AST_LOCK: assert property (@(posedge clk_i) disable iff (!nrst_i)
    wr_en_i && addr_i == tuner_regs_pkg::ADDR_OSC
    |=> ##1 lock_detect_enable_o == $past(wdata_i[2], 2))
    else $error("lock detect enable does not follow write");
  AST_ODIV: assert property (@(posedge clk_i) disable iff (!nrst_i)
    osc_q[1:0] == 2'h3 |=> oscillator_output_divider_o == 4'h8)
    else $error("output divide 32 not selected");
  AST_PUMP: assert property (@(posedge clk_i) disable iff (!nrst_i)
    1'b1 |=> $onehot(pump_current_select_o))
    else $error("pump select not one-hot");
  AST_BAND: assert property (@(posedge clk_i) disable iff (!nrst_i)
    1'b1 |=> filter_band_select_o == $past(ovld_q[1]))
    else $error("filter band wrong");
  AST_FE_PD: assert property (@(posedge clk_i) disable iff (!nrst_i)
    wr_en_i && addr_i == tuner_regs_pkg::ADDR_CTRL
    |=> ##1 front_end_power_down_o == $past(wdata_i[3], 2)
         && gain_amp_power_down_o == $past(wdata_i[2], 2))
    else $error("front end or amp power-down wrong");
  AST_SRC: assert property (@(posedge clk_i) disable iff (!nrst_i)
    ctrl_q[1:0] == 2'h2 |=> high_band_input_o && !low_band_input_o)
    else $error("high band input not selected");
  AST_MIX: assert property (@(posedge clk_i) disable iff (!nrst_i)
    pwr_q[7:6] == tuner_regs_pkg::MIX_ON |=> !mixer_power_down_o)
    else $error("mixer off with enable code");
  AST_SECT_PD: assert property (@(posedge clk_i) disable iff (!nrst_i)
    1'b1 |=> intermediate_stage_power_down_o == $past(pwr_q[5])
         && detector_power_down_o == $past(pwr_q[4])
         && synthesizer_power_down_o == $past(pwr_q[3]))
    else $error("section power-down wrong");
  AST_CAP: assert property (@(posedge clk_i) disable iff (!nrst_i)
    wr_en_i && addr_i == tuner_regs_pkg::ADDR_SER_CAP
    |=> ##1 series_cap_code_o == $past(wdata_i, 2))
    else $error("series cap code wrong");
endmodule : tuner_control_registers

//--- hw/tuner_regs_pkg.sv
//==============================================================
// Contract
// - reference divider holds 7-bit value in bits 6-0, 16..127, bit 7 zero
// - core select 00 powers all cores down; 01,10,11 pick core 1,2,3
// - sub-band field bits 5-3 selects sub-band zero through seven directly
// - oscillator bit 2 enables lock detection when one
// - output divider code 00..11 divides by 4, 8, 16, 32
// - pump current code 00..11 gives 0.5, 1, 1.5, 2 mA
// - filter band bit: zero low VHF band, one UHF band
// - control bit 3 disables the RF front end when one
// - control bit 2 powers down the IF gain amplifier when one
// - source code 00 VHF with LPF, 01 VHF no LPF, 10 UHF, 11 factory
// - mixer code 00 enables, 11 disables; 01 and 10 are factory only
// - shutdown bit 5 powers down the IF section when one
// - shutdown bit 4 disables the IF power detector when one
// - shutdown bit 3 powers down the synthesizer when one
// - series capacitor register drives the tracking filter code directly
// - every register reads back its last written contents with its reserved bits as zero
package tuner_regs_pkg;
  localparam logic [3:0] ADDR_REF_DIV   = 4'h2;
  localparam logic [3:0] ADDR_OSC       = 4'h3;
  localparam logic [3:0] ADDR_OVLD_PUMP = 4'h4;
  localparam logic [3:0] ADDR_CTRL      = 4'h5;
  localparam logic [3:0] ADDR_PWR_DOWN  = 4'h6;
  localparam logic [3:0] ADDR_SER_CAP   = 4'h7;
  // masks of writable bits; reserved bits stay zero
  localparam logic [7:0] MASK_REF_DIV   = 8'h7F;
  localparam logic [7:0] MASK_OSC       = 8'hFF;
  localparam logic [7:0] MASK_OVLD_PUMP = 8'h7E;
  localparam logic [7:0] MASK_CTRL      = 8'h0F;
  localparam logic [7:0] MASK_PWR_DOWN  = 8'hF8;
  localparam logic [7:0] MASK_SER_CAP   = 8'hFF;
  // recommended values loaded at reset
  localparam logic [7:0] RST_REF_DIV    = 8'h40;
  localparam logic [7:0] RST_OSC        = 8'hBE;
  localparam logic [7:0] RST_OVLD_PUMP  = 8'h00;
  localparam logic [7:0] RST_CTRL       = 8'h01;
  localparam logic [7:0] RST_PWR_DOWN   = 8'h00;
  localparam logic [7:0] RST_SER_CAP    = 8'h0F;
  // field positions
  localparam int CORE_LSB  = 6;
  localparam int SUBB_LSB  = 3;
  localparam int LOCK_BIT  = 2;
  localparam int ODIV_LSB  = 0;
  localparam int OVLD_LSB  = 4;
  localparam int PUMP_LSB  = 2;
  localparam int BAND_BIT  = 1;
  localparam int FEPD_BIT  = 3;
  localparam int VGAPD_BIT = 2;
  localparam int SRC_LSB   = 0;
  localparam int MIX_LSB   = 6;
  localparam int IFPD_BIT  = 5;
  localparam int DETPD_BIT = 4;
  localparam int SYNPD_BIT = 3;
  localparam logic [1:0] MIX_ON  = 2'h0;
  localparam logic [1:0] MIX_OFF = 2'h3;
  localparam logic [1:0] SRC_FACTORY = 2'h3;
endpackage : tuner_regs_pkg

//--- hw/reg_byte.sv
`timescale 1ns/1ps
// one masked byte register; reserved bits never store a one
module reg_byte #(
  parameter logic [7:0] MASK  = 8'hFF,
  parameter logic [7:0] RST_V = 8'h00
) (
  input  wire logic       clk_i,
  input  wire logic       nrst_i,
  input  wire logic       we_i,
  input  wire logic [7:0] wdata_i,
  output logic      [7:0] q_o
);
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      q_o <= RST_V & MASK;
    end else if (we_i) begin
      q_o <= wdata_i & MASK;
    end
  end
endmodule : reg_byte

//--- hw/one_hot_dec.sv
`timescale 1ns/1ps
// binary code to one-hot select lines
module one_hot_dec #(
  parameter int W = 2
) (
  input  wire logic [W-1:0]      code_i,
  output logic      [(1<<W)-1:0] sel_o
);
  always_comb begin
    sel_o = '0;
    sel_o[code_i] = 1'b1;
  end
endmodule : one_hot_dec

//--- tb/tuner_control_registers_tb_top.sv
`timescale 1ns/1ps
module tuner_control_registers_tb_top;
  // ============================================================
  // signals
  logic clk_i = 1'b0, nrst_i = 1'b0, wr_en_i = 1'b0, rd_en_i = 1'b0;
  logic [3:0] addr_i = 4'h0;
  logic [7:0] wdata_i = 8'h00, rdata_o, sub_band_sel_o, series_cap_code_o;
  logic [6:0] ref_divide_o;
  logic [3:0] oscillator_output_divider_o, pump_current_select_o;
  logic [2:0] core_enable_o, overload_threshold_o, k;
  logic [1:0] c;
  logic [1:0] rf_source_select_o;
  logic rvalid_o, lock_detect_enable_o, filter_band_select_o, front_end_power_down_o;
  logic gain_amp_power_down_o, low_band_lpf_o, low_band_input_o, high_band_input_o;
  logic mixer_power_down_o, intermediate_stage_power_down_o, detector_power_down_o;
  logic synthesizer_power_down_o;
  int mismatches = 0;
  int num_checks = 0;
  // reset values are the designer's recommended defaults, 0x2 upward
  localparam logic [7:0] RV [6] = '{8'h40, 8'hBE, 8'h00, 8'h01, 8'h00, 8'h0F};

  always #25 clk_i = ~clk_i;

  tuner_control_registers i_dut (
    .clk_i, .nrst_i, .wr_en_i, .rd_en_i, .addr_i, .wdata_i, .rdata_o, .rvalid_o,
    .ref_divide_o, .core_enable_o, .sub_band_sel_o, .lock_detect_enable_o,
    .oscillator_output_divider_o, .overload_threshold_o, .pump_current_select_o,
    .filter_band_select_o, .front_end_power_down_o, .gain_amp_power_down_o,
    .rf_source_select_o, .low_band_lpf_o, .low_band_input_o, .high_band_input_o,
    .mixer_power_down_o, .intermediate_stage_power_down_o, .detector_power_down_o,
    .synthesizer_power_down_o, .series_cap_code_o
  );

  // ============================================================
  // helpers
  function automatic logic [7:0] ext(input logic x);
    return {7'h00, x};
  endfunction : ext

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // waits one extra edge so the decoded outputs have settled
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge clk_i);
    wr_en_i <= 1'b1;
    addr_i  <= a;
    wdata_i <= d;
    @(negedge clk_i);
    wr_en_i <= 1'b0;
    @(negedge clk_i);
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(negedge clk_i);
    rd_en_i <= 1'b1;
    addr_i  <= a;
    @(negedge clk_i);
    rd_en_i <= 1'b0;
    chk("rvalid", 8'h01, ext(rvalid_o));
    chk("rdata", exp, rdata_o);
    @(negedge clk_i);
    chk("rvalid_drop", 8'h00, ext(rvalid_o));
  endtask : rd

  task automatic defaults();
    chk("ref_divide", 8'h40, {1'b0, ref_divide_o});
    chk("core", 8'h02, {5'h00, core_enable_o});
    chk("sub_band", 8'h80, sub_band_sel_o);
    chk("lock", 8'h01, ext(lock_detect_enable_o));
    chk("out_div", 8'h04, {4'h0, oscillator_output_divider_o});
    chk("low_band", 8'h01, ext(low_band_input_o));
    chk("cap", 8'h0F, series_cap_code_o);
    for (int i = 0; i < 6; i++) rd(4'(i + 2), RV[i]);
  endtask : defaults

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : print_verdict

  // ============================================================
  // tests
  initial begin
    #400_000;
    mismatches++;
    print_verdict();
  end

  initial begin
    repeat (5) @(negedge clk_i);
    nrst_i <= 1'b1;
    @(negedge clk_i);
    defaults();
    $display("test reset_defaults done");
    // software must not write before the power-up settling time has passed
    repeat (2000) @(negedge clk_i);
    for (int i = 0; i < 8; i++) begin
      k = 3'(i);
      wr(tuner_regs_pkg::ADDR_OSC, {k[1:0], k, k[0], k[1:0]});
      chk("core", k[1:0] == 2'h0 ? 8'h00 : 8'h01 << (k[1:0] - 2'h1), {5'h00, core_enable_o});
      chk("sub_band", 8'h01 << k, sub_band_sel_o);
      chk("lock", ext(k[0]), ext(lock_detect_enable_o));
      chk("out_div", 8'h01 << k[1:0], {4'h0, oscillator_output_divider_o});
    end
    $display("test oscillator done");
    for (int i = 0; i < 4; i++) begin
      k = 3'(i);
      // source code 11 is factory only, so the last pass uses 10 again
      c = (k == 3'h3) ? 2'h2 : k[1:0];
      wr(tuner_regs_pkg::ADDR_OVLD_PUMP, {1'b0, k, k[1:0], k[0], 1'b0});
      chk("threshold", {5'h00, k}, {5'h00, overload_threshold_o});
      chk("pump", 8'h01 << k[1:0], {4'h0, pump_current_select_o});
      chk("band", ext(k[0]), ext(filter_band_select_o));
      rd(tuner_regs_pkg::ADDR_OVLD_PUMP, {1'b0, k, k[1:0], k[0], 1'b0});
      wr(tuner_regs_pkg::ADDR_CTRL, {4'h0, k[0], k[1], c});
      chk("front_end", ext(k[0]), ext(front_end_power_down_o));
      chk("gain_amp", ext(k[1]), ext(gain_amp_power_down_o));
      chk("src", {6'h00, c}, {6'h00, rf_source_select_o});
      chk("lpf", ext(c == 2'h0), ext(low_band_lpf_o));
      chk("low_in", ext(c < 2'h2), ext(low_band_input_o));
      chk("high_in", ext(c == 2'h2), ext(high_band_input_o));
      rd(tuner_regs_pkg::ADDR_CTRL, {4'h0, k[0], k[1], c});
      // mixer codes 01 and 10 are factory only; use 00 for two passes, then 11
      wr(tuner_regs_pkg::ADDR_PWR_DOWN, {k[1], k[1], k[0], k[1], ~k[0], 3'h0});
      chk("mixer", ext(k[1]), ext(mixer_power_down_o));
      chk("if_pd", ext(k[0]), ext(intermediate_stage_power_down_o));
      chk("det_pd", ext(k[1]), ext(detector_power_down_o));
      chk("syn_pd", ext(~k[0]), ext(synthesizer_power_down_o));
      rd(tuner_regs_pkg::ADDR_PWR_DOWN, {k[1], k[1], k[0], k[1], ~k[0], 3'h0});
    end
    $display("test field_decode done");
    wr(tuner_regs_pkg::ADDR_REF_DIV, 8'h10);
    chk("ref_divide", 8'h10, {1'b0, ref_divide_o});
    rd(tuner_regs_pkg::ADDR_REF_DIV, 8'h10);
    wr(tuner_regs_pkg::ADDR_REF_DIV, 8'h7F);
    chk("ref_divide", 8'h7F, {1'b0, ref_divide_o});
    wr(tuner_regs_pkg::ADDR_SER_CAP, 8'hA5);
    chk("cap", 8'hA5, series_cap_code_o);
    wr(tuner_regs_pkg::ADDR_SER_CAP, 8'h5A);
    chk("cap", 8'h5A, series_cap_code_o);
    // unmapped write must leave every mapped register alone
    wr(4'h8, 8'hFF);
    rd(4'h8, 8'h00);
    rd(tuner_regs_pkg::ADDR_SER_CAP, 8'h5A);
    // read and write in the same cycle: read sees the old byte
    @(negedge clk_i);
    wr_en_i <= 1'b1;
    rd_en_i <= 1'b1;
    addr_i  <= tuner_regs_pkg::ADDR_SER_CAP;
    wdata_i <= 8'h3C;
    @(negedge clk_i);
    wr_en_i <= 1'b0;
    rd_en_i <= 1'b0;
    chk("rdata_old", 8'h5A, rdata_o);
    rd(tuner_regs_pkg::ADDR_SER_CAP, 8'h3C);
    // write then read in the very next cycle
    @(negedge clk_i);
    wr_en_i <= 1'b1;
    addr_i  <= tuner_regs_pkg::ADDR_SER_CAP;
    wdata_i <= 8'hC3;
    @(negedge clk_i);
    wr_en_i <= 1'b0;
    rd_en_i <= 1'b1;
    @(negedge clk_i);
    rd_en_i <= 1'b0;
    chk("rdata_b2b", 8'hC3, rdata_o);
    $display("test boundaries done");
    nrst_i <= 1'b0;
    @(negedge clk_i);
    chk("pd_in_reset", 8'h3F, {2'h0, front_end_power_down_o, gain_amp_power_down_o,
        mixer_power_down_o, intermediate_stage_power_down_o,
        detector_power_down_o, synthesizer_power_down_o});
    nrst_i <= 1'b1;
    @(negedge clk_i);
    defaults();
    $display("test mid_reset done");
    print_verdict();
  end
endmodule : tuner_control_registers_tb_top
